// file: tof_consts.svh
// Purpose: shared constants of the time-of-flight readout link
// Assumes: included by bare name from the device, host and test files
// Notes: device offsets are link addresses, host offsets are apb bytes
`ifndef TOF_CONSTS_SVH
`define TOF_CONSTS_SVH
`define PCLK_MHZ 200
`define ROWS 60
`define COLS 160
// ****************************************
// device register map
// ****************************************
`define REG_DIV 8'h88
`define REG_SIR 8'h9d
`define REG_RAMP 8'hcd
`define REG_MODE 8'he0
`define REG_OUTC 8'he1
`define REG_PLEN 8'he2
`define REG_SLEN 8'he3
`define REG_TLO 8'he4
`define REG_THI 8'he5
`define REG_STAT 8'he6
`define DIV_RST 8'h3f
`define SIR_RST 8'h50
`define RAMP_RST 8'h13
`define MODE_RST 8'h00
`define OUTC_RST 8'h05
`define LEN_RST 8'h40
// ****************************************
// field positions
// ****************************************
`define M_DUAL 0
`define M_SECOND 1
`define M_PAIR 2
`define M_GRAY 3
`define M_SKIP 4
`define M_TWOS 5
`define O_FMT_LO 0
`define O_SATSEL 2
`define O_FORCE 3
`define R_RESSEL 3
`define R_NUMLSB_LO 6
`define FMT_8BIT 2'h3
`define SAT_CODE 12'hfff
// ****************************************
// conversion times per row
// ****************************************
`define CONV8_NS 12250
`define CONV9_NS 13125
`define CONV10_NS 14000
`define CONV11_NS 14875
`define CONV12_NS 15750
`define NS_TO_CYC(ns) ((((ns) * `PCLK_MHZ) + 999) / 1000)
// ****************************************
// host: resolution tables, index 0 = 8 bit
// ****************************************
`define TBL_RAMP 40'h13db9b5b1b
`define TBL_DIV 40'h3f3a342e27
`define TBL_SIR 40'h5049423b34
`define H_CTRL 8'h00
`define H_RES 8'h04
`define H_CMD 8'h08
`define H_STAT 8'h0c
`define H_KEPT 8'h10
`define H_DISC 8'h14
`define H_FRAMES 8'h18
`endif

// file: tof_pkg.sv
// Purpose: types shared by both ends of the readout link
// Assumes: nothing
// Notes: sequencer states are gray coded along the usual path; host wait to idle flips both bits
package tof_pkg;
  typedef logic [1:0] gate_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_INTEG = 2'b01, S_CONV = 2'b11, S_STREAM = 2'b10
  } seq_state_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_REQ = 2'b01, H_WAIT = 2'b11
  } host_state_t;
endpackage

// file: tof_link_if.sv
// Purpose: link between the imager readout and its receiving host
// Assumes: both ends clocked by the same pclk
// Notes: register port is a one-cycle strobe answered by reg_ack
`timescale 1ns/1ps
`default_nettype none
interface tof_link_if;
  logic shutter;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_ack;
  logic vsync;
  logic hsync;
  logic [11:0] pix_data;
  logic sat_pin;
  modport dev(input shutter, reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_ack, vsync, hsync, pix_data, sat_pin);
  modport host(output shutter, reg_wr, reg_rd, reg_addr, reg_wdata,
    input reg_rdata, reg_ack, vsync, hsync, pix_data, sat_pin);
endinterface
`default_nettype wire

// file: tof_device.sv
// Purpose: imager readout control: gate groups, adc resolution, row
//   readout with saturation flag, temperature accumulation
// Assumes: link strobes synchronous to pclk, one access at a time
// Notes: pixel and temperature codes arrive on plain inputs
//
// What this block does
// RL1 - dual phase mode: groups capture samples 0/2, 1/3
// RL2 - phase mode still reads all 160x60 pixels
// RL3 - hdr mode: same phases, separate stop times
// RL4 - hdr: upper primary length, lower secondary length
// RL5 - either hdr length may be the shorter
// RL6 - adc 12 bit default, reducible to 8..11
// RL7 - row conversion 12.25 to 15.75 us
// RL8 - host programs signed resolution table values
// RL9 - host rewrites ramp current and divider together
// RL10 - 8 bit: resolution select 1, lsb count 00
// RL11 - reduced resolution combines with 8 bit format
// RL12 - grayscale sign bit: 1 unsigned, 0 signed
// RL13 - sign skip at 8 bit converts 9 bits
// RL14 - sign skip: lsb counts give 10/11/12 bits
// RL15 - host programs sign-skip table values
// RL16 - saturation flag with every sample
// RL17 - binning: flag on any gate or sum
// RL18 - flag on sync pin with data bits
// RL19 - saturation forcing outputs 0xfff
// RL20 - host discards 0xfff samples when forcing
// RL21 - temperature summed over four rows, 14 bit
// RL22 - frame start clears temperature accumulator and valid bit
// RL23 - temperature sum readable during acquisition
// RL24 - mode changes take effect at frame start
`timescale 1ns/1ps
`default_nettype none
`include "tof_consts.svh"
module tof_device #(
  parameter int ROWS = `ROWS,
  parameter int COLS = `COLS
) (
  input wire logic pclk,
  input wire logic presetn,
  tof_link_if.dev link,
  input wire logic [11:0] pix_code,
  input wire logic pix_gate_sat,
  input wire logic pix_sum_sat,
  input wire logic [11:0] temp_code,
  output tof_pkg::gate_t upper_gate_group,
  output tof_pkg::gate_t lower_gate_group
);
  import tof_pkg::*;
  localparam int RW = $clog2(ROWS);
  localparam int CW = $clog2(COLS);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [11:0] conv_cyc(input logic [3:0] bits);
    case (bits)
      4'd8: conv_cyc = 12'(`NS_TO_CYC(`CONV8_NS)); // RL7
      4'd9: conv_cyc = 12'(`NS_TO_CYC(`CONV9_NS));
      4'd10: conv_cyc = 12'(`NS_TO_CYC(`CONV10_NS));
      4'd11: conv_cyc = 12'(`NS_TO_CYC(`CONV11_NS));
      default: conv_cyc = 12'(`NS_TO_CYC(`CONV12_NS));
    endcase
  endfunction

  function automatic logic [1:0] wave(input logic [1:0] ph,
                                      input logic [1:0] k,
                                      input logic on);
    logic [1:0] p;
    p = ph + k;
    wave = on ? {~p[1], p[1]} : 2'b00;
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] div_r, sir_r, ramp_r, mode_r, outc_r, plen_r, slen_r;
  logic [7:0] act_ramp_r, act_mode_r, act_outc_r, act_plen_r, act_slen_r;
  logic [13:0] tsum_r, tacc_r;
  logic [2:0] tcnt_r;
  logic tvalid_r;
  seq_state_t st_r;
  logic [11:0] cnt_r;
  logic [RW-1:0] row_r;
  logic [CW-1:0] col_r;
  logic [1:0] ph_r;

  wire acc_wr = link.reg_wr;
  wire [7:0] a = link.reg_addr;
  wire idle = (st_r == S_IDLE);
  wire start = idle && link.shutter;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= `DIV_RST;
      sir_r <= `SIR_RST;
      ramp_r <= `RAMP_RST; // RL6
      mode_r <= `MODE_RST;
      outc_r <= `OUTC_RST;
      plen_r <= `LEN_RST;
      slen_r <= `LEN_RST;
    end else if (acc_wr) begin
      if (a == `REG_DIV) div_r <= link.reg_wdata;
      if (a == `REG_SIR) sir_r <= link.reg_wdata;
      if (a == `REG_RAMP) ramp_r <= link.reg_wdata;
      if (a == `REG_MODE) mode_r <= link.reg_wdata;
      if (a == `REG_OUTC) outc_r <= link.reg_wdata;
      if (a == `REG_PLEN) plen_r <= link.reg_wdata;
      if (a == `REG_SLEN) slen_r <= link.reg_wdata;
    end
  end

  // software may rewrite settings mid-frame; the frame keeps its copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ramp_r <= `RAMP_RST;
      act_mode_r <= `MODE_RST;
      act_outc_r <= `OUTC_RST;
      act_plen_r <= `LEN_RST;
      act_slen_r <= `LEN_RST;
    end else if (start) begin
      act_ramp_r <= ramp_r; // RL24
      act_mode_r <= mode_r; // RL24
      act_outc_r <= outc_r;
      act_plen_r <= plen_r;
      act_slen_r <= slen_r;
    end
  end

  // ****************************************
  // mode and resolution decode
  // ****************************************
  wire dual = act_mode_r[`M_DUAL];
  wire hdr = dual && act_mode_r[`M_SECOND];
  wire phs = dual && !act_mode_r[`M_SECOND];
  wire res_sel = act_ramp_r[`R_RESSEL];
  wire [1:0] numlsb = act_ramp_r[`R_NUMLSB_LO +: 2];
  wire skip = act_mode_r[`M_SKIP] && res_sel;
  // 8 bit needs res_sel 1 and numlsb 00; skip adds one converted bit
  wire [3:0] eff_bits = res_sel ? 4'd8 + {2'b00, numlsb} : 4'd12; // RL10
  wire [3:0] cbits = eff_bits + {3'b000, skip}; // RL13 RL14
  wire [11:0] conv_len = conv_cyc(cbits); // RL7
  wire [7:0] low_len = hdr ? act_slen_r : act_plen_r; // RL4
  // no ordering between the two lengths: run to the longer one
  wire [7:0] int_len = (low_len > act_plen_r) ? low_len : act_plen_r; // RL5
  wire [1:0] up_k = {act_mode_r[`M_PAIR], 1'b0};
  wire [1:0] lo_k = phs ? up_k + 2'd1 : up_k; // RL1 RL3
  wire integ = (st_r == S_INTEG);
  wire up_on = integ && (cnt_r < {4'h0, act_plen_r}); // RL4
  wire lo_on = integ && (cnt_r < {4'h0, low_len}); // RL3

  // ****************************************
  // row sequencer
  // ****************************************
  wire conv_done = (st_r == S_CONV) && (cnt_r == conv_len - 12'd1);
  wire row_end = (st_r == S_STREAM) && (col_r == CW'(COLS - 1));
  wire last_row = (row_r == RW'(ROWS - 1));
  wire row_tick = (st_r == S_CONV) && (cnt_r == 12'd0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      cnt_r <= 12'h000;
      row_r <= '0;
      col_r <= '0;
    end else begin
      case (st_r)
        S_IDLE: begin
          cnt_r <= 12'h000;
          if (link.shutter) st_r <= S_INTEG;
        end
        S_INTEG: begin
          cnt_r <= cnt_r + 12'd1;
          if (cnt_r >= {4'h0, int_len}) begin
            st_r <= S_CONV;
            cnt_r <= 12'h000;
            row_r <= '0;
          end
        end
        S_CONV: begin
          cnt_r <= cnt_r + 12'd1;
          if (conv_done) begin
            st_r <= S_STREAM;
            col_r <= '0;
          end
        end
        S_STREAM: begin
          col_r <= col_r + CW'(1);
          if (row_end) begin
            cnt_r <= 12'h000;
            // whole array every frame, in every dual mode
            if (last_row) st_r <= S_IDLE; // RL2
            else begin
              row_r <= row_r + RW'(1);
              st_r <= S_CONV;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= 2'b00;
      upper_gate_group <= 2'b00;
      lower_gate_group <= 2'b00;
    end else begin
      ph_r <= ph_r + 2'd1;
      upper_gate_group <= wave(ph_r, up_k, up_on); // RL1 RL3
      lower_gate_group <= wave(ph_r, lo_k, lo_on); // RL1 RL3
    end
  end

  // ****************************************
  // sample formatting
  // ****************************************
  wire gray = act_mode_r[`M_GRAY];
  wire twos = act_mode_r[`M_TWOS];
  wire f8 = (act_outc_r[`O_FMT_LO +: 2] == `FMT_8BIT); // RL11
  wire satsel = act_outc_r[`O_SATSEL];
  wire force_sat = act_outc_r[`O_FORCE];
  wire sat = pix_gate_sat | pix_sum_sat; // RL17
  wire [11:0] mask = 12'hfff << (4'd12 - cbits);
  wire [11:0] v0 = pix_code & mask;
  // single-ended conversion always carries a fixed sign msb
  wire [11:0] v1 = gray ? {~twos, v0[10:0]} : v0; // RL12
  wire [11:0] v2 = skip ? {v1[10:0], 1'b0} : v1; // RL13
  wire [11:0] v3 = f8 ? {4'h0, v2[11:4]} : v2; // RL11
  wire [11:0] vout = (force_sat && sat) ? `SAT_CODE : v3; // RL19
  wire streaming = (st_r == S_STREAM);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.hsync <= 1'b0;
      link.vsync <= 1'b0;
      link.pix_data <= 12'h000;
      link.sat_pin <= 1'b0;
    end else begin
      link.hsync <= streaming;
      link.vsync <= (st_r == S_CONV) || streaming;
      link.pix_data <= streaming ? vout : 12'h000;
      // flag travels in the same cycle as its data word
      link.sat_pin <= satsel ? (streaming && sat) // RL16 RL18
                             : (row_end && last_row);
    end
  end

  // ****************************************
  // temperature accumulation
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tacc_r <= 14'h0000;
      tcnt_r <= 3'd0;
      tsum_r <= 14'h0000;
      tvalid_r <= 1'b0;
    end else if (start) begin
      tacc_r <= 14'h0000; // RL22
      tcnt_r <= 3'd0;
      tvalid_r <= 1'b0; // RL22
    end else if (row_tick) begin
      if (tcnt_r == 3'd3) begin
        tsum_r <= tacc_r + {2'b00, temp_code}; // RL21
        tvalid_r <= 1'b1;
        tacc_r <= 14'h0000;
        tcnt_r <= 3'd0;
      end else begin
        tacc_r <= tacc_r + {2'b00, temp_code}; // RL21
        tcnt_r <= tcnt_r + 3'd1;
      end
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  wire [7:0] rd_val =
    (a == `REG_DIV) ? div_r :
    (a == `REG_SIR) ? sir_r :
    (a == `REG_RAMP) ? ramp_r :
    (a == `REG_MODE) ? mode_r :
    (a == `REG_OUTC) ? outc_r :
    (a == `REG_PLEN) ? plen_r :
    (a == `REG_SLEN) ? slen_r :
    (a == `REG_TLO) ? tsum_r[7:0] : // RL23
    (a == `REG_THI) ? {tvalid_r, 1'b0, tsum_r[13:8]} : // RL23
    (a == `REG_STAT) ? {6'h00, st_r} : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.reg_ack <= 1'b0;
      link.reg_rdata <= 8'h00;
    end else begin
      link.reg_ack <= link.reg_wr | link.reg_rd;
      if (link.reg_rd) link.reg_rdata <= rd_val;
    end
  end
endmodule
`default_nettype wire

// file: tof_host.sv
// Purpose: receiving host: apb registers, device programming, sample intake
// Assumes: one device on the link, same pclk
// Notes: one wait state on every apb access
`timescale 1ns/1ps
`default_nettype none
`include "tof_consts.svh"
module tof_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output tof_pkg::host_state_t link_state,
  tof_link_if.host link
);
  import tof_pkg::*;

  // ****************************************
  // apb slave
  // ****************************************
  logic disc_en_r, go_r;
  logic [2:0] res_r;
  logic skip_r;
  logic [16:0] cmd_r;
  logic [7:0] rdat_r;
  logic [1:0] jobs_r;
  logic job_cmd_r;
  logic [31:0] kept_r, disc_r, frames_r;
  logic vs_d_r;

  wire busy = (jobs_r != 2'd0);
  wire acc = psel && penable && pready;
  wire [2:0] tidx = res_r + {2'b00, skip_r};
  // sign skip has no 12 bit entry
  wire res_bad = (pwdata[2:0] > 3'd4) || (pwdata[3] && pwdata[2:0] == 3'd4);
  wire wr_res = acc && pwrite && paddr == `H_RES && !busy && !res_bad;
  wire wr_cmd = acc && pwrite && paddr == `H_CMD && !busy;
  wire known = paddr == `H_CTRL || paddr == `H_RES || paddr == `H_CMD ||
    paddr == `H_STAT || paddr == `H_KEPT || paddr == `H_DISC ||
    paddr == `H_FRAMES;
  wire err = !known || (pwrite && busy &&
    (paddr == `H_RES || paddr == `H_CMD)) ||
    (pwrite && paddr == `H_RES && res_bad);
  wire [31:0] rd_val =
    (paddr == `H_CTRL) ? {30'h0, disc_en_r, 1'b0} :
    (paddr == `H_RES) ? {28'h0, skip_r, res_r} :
    (paddr == `H_CMD) ? {15'h0, cmd_r} :
    (paddr == `H_STAT) ? {16'h0, rdat_r, 7'h0, busy} :
    (paddr == `H_KEPT) ? kept_r :
    (paddr == `H_DISC) ? disc_r :
    (paddr == `H_FRAMES) ? frames_r : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      disc_en_r <= 1'b0;
      go_r <= 1'b0;
      res_r <= 3'd4;
      skip_r <= 1'b0;
      cmd_r <= 17'h0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && err;
      prdata <= (psel && penable && !pready && !pwrite) ? rd_val : 32'h0;
      go_r <= acc && pwrite && paddr == `H_CTRL && pwdata[0];
      if (acc && pwrite && paddr == `H_CTRL) disc_en_r <= pwdata[1];
      if (wr_res) begin
        res_r <= pwdata[2:0];
        skip_r <= pwdata[3];
      end
      if (wr_cmd) cmd_r <= pwdata[16:0];
    end
  end

  // ****************************************
  // link access engine
  // ****************************************
  // a resolution change always rewrites all three values back to back
  wire [7:0] j_addr = job_cmd_r ? cmd_r[15:8] :
    (jobs_r == 2'd3) ? `REG_RAMP :
    (jobs_r == 2'd2) ? `REG_DIV : `REG_SIR; // RL9
  wire [39:0] tbl = (jobs_r == 2'd3) ? `TBL_RAMP :
    (jobs_r == 2'd2) ? `TBL_DIV : `TBL_SIR; // RL8 RL15
  wire [7:0] j_data = job_cmd_r ? cmd_r[7:0] : tbl[{tidx, 3'b000} +: 8];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_state <= H_IDLE;
      jobs_r <= 2'd0;
      job_cmd_r <= 1'b0;
      rdat_r <= 8'h00;
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      link.reg_addr <= 8'h00;
      link.reg_wdata <= 8'h00;
      link.shutter <= 1'b0;
    end else begin
      link.shutter <= go_r;
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      case (link_state)
        H_IDLE: begin
          if (wr_res) begin
            jobs_r <= 2'd3; // RL9
            job_cmd_r <= 1'b0;
            link_state <= H_REQ;
          end else if (wr_cmd) begin
            jobs_r <= 2'd1;
            job_cmd_r <= 1'b1;
            link_state <= H_REQ;
          end
        end
        H_REQ: begin
          link.reg_addr <= j_addr;
          link.reg_wdata <= j_data;
          link.reg_wr <= !(job_cmd_r && cmd_r[16]);
          link.reg_rd <= job_cmd_r && cmd_r[16];
          link_state <= H_WAIT;
        end
        H_WAIT: begin
          if (link.reg_ack) begin
            if (job_cmd_r && cmd_r[16]) rdat_r <= link.reg_rdata;
            jobs_r <= jobs_r - 2'd1;
            link_state <= (jobs_r == 2'd1) ? H_IDLE : H_REQ;
          end
        end
        default: link_state <= H_IDLE;
      endcase
    end
  end

  // ****************************************
  // sample intake
  // ****************************************
  wire is_sat = disc_en_r && link.pix_data == `SAT_CODE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kept_r <= 32'h0;
      disc_r <= 32'h0;
      frames_r <= 32'h0;
      vs_d_r <= 1'b0;
    end else begin
      vs_d_r <= link.vsync;
      if (link.hsync && is_sat) disc_r <= disc_r + 32'd1; // RL20
      if (link.hsync && !is_sat) kept_r <= kept_r + 32'd1; // RL20
      if (vs_d_r && !link.vsync) frames_r <= frames_r + 32'd1;
    end
  end
endmodule
`default_nettype wire

// file: tof_readout_properties.sv
// Purpose: protocol checks on the link between host and imager
// Assumes: one pclk domain, shutter only while the imager is idle
// Notes: temperature checks count hsync falls since shutter; row check counts hsync cycles
`timescale 1ns/1ps
`default_nettype none
module tof_readout_properties #(
  parameter int COLS = 160
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic shutter,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic vsync,
  input wire logic hsync
);
  logic [8:0] hs_r;
  logic [2:0] rows_r;
  wire strobe = reg_wr | reg_rd;
  wire temp_rd = reg_rd & (reg_addr == 8'he5);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // helper counters
  // ****************************************
  // rows saturate so a finished frame keeps reading as valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_r <= 9'h0;
      rows_r <= 3'h0;
    end else begin
      hs_r <= hsync ? hs_r + 9'h1 : 9'h0;
      if (shutter) begin
        rows_r <= 3'h0;
      end else if (hs_r != 9'h0 && !hsync && rows_r != 3'h7) begin
        rows_r <= rows_r + 3'h1;
      end
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  ack_after_strobe_a: assert property (
    strobe |=> reg_ack ##1 !reg_ack)
    else $error("register strobe not acknowledged next cycle");
  ack_has_cause_a: assert property (reg_ack |-> $past(strobe))
    else $error("acknowledge without a strobe");
  strobe_spacing_a: assert property (strobe |=> !strobe)
    else $error("register strobes back to back");
  rdata_holds_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  hsync_in_frame_a: assert property (hsync |-> vsync)
    else $error("row valid outside frame");
  row_length_a: assert property ($fell(hsync) |-> hs_r == COLS)
    else $error("row length wrong");
  temp_valid_a: assert property (
    temp_rd && rows_r >= 3'h4 |=> reg_rdata[7])
    else $error("temperature sum not valid after four rows");
  temp_clear_a: assert property (
    temp_rd && rows_r < 3'h3 |=> !reg_rdata[7])
    else $error("temperature sum valid too early");
  cover property (shutter);
  cover property ($fell(vsync));
  cover property (temp_rd);
endmodule
`default_nettype wire

// file: test_tof_pixel_readout_control.sv
// Purpose: end to end test of host and imager readout over the link
// Assumes: both ends on one pclk
// Notes: frames cut to six rows so the run stays short
`timescale 1ns/1ps
`default_nettype none
`include "tof_consts.svh"
module test_tof_pixel_readout_control;
  import tof_pkg::*;
  localparam int ROWS = 6;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, gsat = 0, ssat = 0;
  logic [11:0] pcode = 12'h2a5;
  gate_t up, lo;
  int n_errors = 0, checks = 0, un = 0, ln = 0, dif = 0;
  tof_link_if lk();
  tof_device #(.ROWS(ROWS), .COLS(`COLS)) u_tof_device(.pclk(pclk),
    .presetn(presetn), .link(lk.dev), .pix_code(pcode),
    .pix_gate_sat(gsat), .pix_sum_sat(ssat), .temp_code(12'h123),
    .upper_gate_group(up), .lower_gate_group(lo));
  tof_host u_tof_host(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_state(),
    .link(lk.host));
  tof_readout_properties #(.COLS(`COLS)) u_tof_readout_properties(
    .pclk(pclk), .presetn(presetn), .shutter(lk.shutter),
    .reg_wr(lk.reg_wr), .reg_rd(lk.reg_rd), .reg_addr(lk.reg_addr),
    .reg_rdata(lk.reg_rdata), .reg_ack(lk.reg_ack), .vsync(lk.vsync),
    .hsync(lk.hsync));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // gate activity is counted all the time so integration is never missed
  always @(posedge pclk) begin
    un += (up !== 2'b00);
    ln += (lo !== 2'b00);
    dif += (up !== 2'b00 && lo !== 2'b00 && up !== lo);
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    $display("[FAIL] wait expected done seen timeout");
    test_done();
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic idle();
    int i;
    for (i = 0; i < 40; i++) begin
      apb(1'b0, `H_STAT, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 40) hang();
  endtask
  task automatic dev(input logic r, input logic [7:0] a, d);
    apb(1'b1, `H_CMD, {15'h0, r, a, d});
    idle();
  endtask
  task automatic dchk(input logic [7:0] a, e);
    dev(1'b1, a, 8'h00);
    chk($sformatf("dev %h", a), rd[15:8], e);
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                      input logic e);
    apb(1'b1, a, d);
    chk($sformatf("err %h", a), err, e);
  endtask
  task automatic frame(input string nm, input int gap, ue, le,
                       input logic same, sat_on, input logic [12:0] dx);
    int i, low = 0, g = 0, hs = 0, bd = 0, bs = 0;
    logic seen = 1'b0;
    un = 0;
    ln = 0;
    dif = 0;
    apb(1'b1, `H_CTRL, 32'h3);
    for (i = 0; i < 30000; i++) begin
      @(posedge pclk);
      if (lk.vsync === 1'b1) seen = 1'b1;
      else if (seen) break;
      if (lk.hsync === 1'b1) begin
        if (hs > 0 && low > 0) g = low;
        low = 0;
        hs++;
        bd += (dx[12] && lk.pix_data !== dx[11:0]);
        bs += (sat_on && lk.sat_pin !== gsat);
      end else if (seen) low++;
    end
    if (i == 30000) hang();
    chk({nm, " samples"}, hs, `COLS * ROWS);
    chk({nm, " gap"}, g, gap);
    chk({nm, " data"}, bd, 0);
    chk({nm, " sat"}, bs, 0);
    chk({nm, " upper"}, un, ue);
    chk({nm, " lower"}, ln, le);
    chk({nm, " phase"}, dif != 0, !same);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    dchk(`REG_RAMP, 8'h13);
    dchk(`REG_DIV, 8'h3f);
    dchk(`REG_SIR, 8'h50);
    dchk(`REG_THI, 8'h00);
    $display("test reset done");
  endtask
  task automatic test_full();
    gsat <= 1'b1;
    // grayscale, unsigned: fixed sign msb of 1 over the raw code
    dev(1'b0, `REG_MODE, 8'h08);
    frame("full", 3150, 64, 64, 1'b1, 1'b1, {1'b1, 12'haa5});
    dchk(`REG_TLO, 8'h8c);
    dchk(`REG_THI, 8'h84);
    $display("test full done");
  endtask
  task automatic test_hdr();
    wchk(`H_RES, 32'h0, 1'b0);
    idle();
    dchk(`REG_RAMP, 8'h1b);
    dchk(`REG_DIV, 8'h27);
    dchk(`REG_SIR, 8'h34);
    dev(1'b0, `REG_MODE, 8'h03);
    dev(1'b0, `REG_PLEN, 8'h04);
    dev(1'b0, `REG_SLEN, 8'h0a);
    dev(1'b0, `REG_OUTC, 8'h0b);
    // only the binned-sum flag is set, forcing must still trigger
    gsat <= 1'b0;
    ssat <= 1'b1;
    frame("hdr", 2450, 4, 10, 1'b1, 1'b0, {1'b1, 12'hfff});
    apb(1'b0, `H_DISC, 32'h0);
    chk("discarded", rd, `COLS * ROWS);
    apb(1'b0, `H_KEPT, 32'h0);
    chk("kept", rd, `COLS * ROWS);
    apb(1'b0, `H_FRAMES, 32'h0);
    chk("frames", rd, 32'h2);
    $display("test hdr done");
  endtask
  task automatic test_skip();
    wchk(`H_RES, 32'h8, 1'b0);
    idle();
    wchk(`H_RES, 32'hc, 1'b1);
    wchk(`H_RES, 32'h5, 1'b1);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    dchk(`REG_RAMP, 8'h5b);
    dchk(`REG_DIV, 8'h2e);
    dchk(`REG_SIR, 8'h3b);
    dev(1'b0, `REG_MODE, 8'h19);
    dev(1'b0, `REG_PLEN, 8'h08);
    dev(1'b0, `REG_OUTC, 8'h05);
    gsat <= 1'b0;
    ssat <= 1'b0;
    // lsb count 01 with skip converts 10 bits; sign msb shifted out
    frame("skip", 2800, 8, 8, 1'b0, 1'b1, {1'b1, 12'h548});
    $display("test skip done");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset();
    test_full();
    test_hdr();
    test_skip();
    test_done();
  end
endmodule
`default_nettype wire
